// *** tube_mill_shear_sequencer.sv ***
// shear cycle sequencer: shear dwell, dump table, oil mister, scrap marking
// assumes apb master on pclk; pins are asynchronous and synchronised here;
// shear_cmd and part_end come from the length logic on pclk
//
// What this block does
// - test request acts like scrap sensor
// - dump starts after dump delay expires
// - dump held for the dump dwell, within one tick
// - mist once per programmed shear count
// - mist count zero disables misting
// - mist waits mist delay after dwell
// - mist held for mist dwell
// - test parts use test length setting
// - continuous flow forces auto crop on run
// - no continuous flow, no crop, manual normal
// - mist counter preloaded at power up
// - continuous flow: manual homes or ignored
// - scrap sensor marks part under sensor
// - scrap selector follows current part status, frozen while dumping
`timescale 1ns/1ps
`default_nettype none

module tube_mill_shear_sequencer #(
   parameter int TICK_DIV = shear_seq_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic run_mode_pin,
   input wire logic manual_shear_pin,
   input wire logic shear_complete_pin,
   input wire logic scrap_sensor_pin,
   input wire logic shear_cmd,
   input wire logic part_end,
   input wire logic cur_part_scrap,
   output logic shear_out,
   output logic dump_trigger,
   output logic scrap_dump_sel,
   output logic mist_out,
   output logic auto_crop,
   output logic home_ref,
   output logic scrap_mark,
   output logic test_part,
   output logic [15:0] test_part_len,
   output logic scrap_detect_en
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pin_meta_q;
   logic [3:0] pin_q;
   logic run_prev_q;
   logic man_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_q <= 4'h0;
         pin_q <= 4'h0;
         {man_prev_q, run_prev_q} <= 2'b00;
      end else begin
         pin_meta_q <= {scrap_sensor_pin, shear_complete_pin, manual_shear_pin, run_mode_pin};
         pin_q <= pin_meta_q;
         {man_prev_q, run_prev_q} <= pin_q[1:0];
      end
   end

   wire logic run_lvl = pin_q[0];
   wire logic complete_lvl = pin_q[2];
   wire logic sensor_lvl = pin_q[3];
   wire logic run_rise = pin_q[0] & ~run_prev_q;
   wire logic run_fall = ~pin_q[0] & run_prev_q;
   wire logic man_rise = pin_q[1] & ~man_prev_q;

   // ----------------------------------------------------------------
   // apb register file
   // ----------------------------------------------------------------
   shear_seq_pkg::cfg_t cfg_q;
   logic [31:0] prdata_q;
   logic test_req_q;

   wire logic setup_ph = psel & ~penable;
   wire logic access_ph = psel & penable;
   wire logic wr_en = access_ph & pwrite;

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a <= shear_seq_pkg::ADDR_STATUS) && (a[1:0] == 2'b00);
   endfunction

   // slave never stalls; access phase always completes
   assign pready = 1'b1;
   assign pslverr = access_ph & ~addr_known(paddr);
   assign prdata = prdata_q;

   logic [31:0] status_w;
   logic [31:0] rd_mux;
   logic [15:0] mist_cnt_q;
   logic scrap_lock_q;
   assign status_w = {mist_cnt_q, 10'h000, run_lvl, scrap_lock_q, scrap_dump_sel, mist_out,
                      dump_trigger, shear_out};

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         shear_seq_pkg::ADDR_CTRL: rd_mux = {31'h0000_0000, cfg_q.cflow};
         shear_seq_pkg::ADDR_DUMP_DELAY: rd_mux = 32'(cfg_q.dump_delay);
         shear_seq_pkg::ADDR_DUMP_DWELL: rd_mux = 32'(cfg_q.dump_dwell);
         shear_seq_pkg::ADDR_MIST_COUNT: rd_mux = 32'(cfg_q.mist_count);
         shear_seq_pkg::ADDR_MIST_DELAY: rd_mux = 32'(cfg_q.mist_delay);
         shear_seq_pkg::ADDR_MIST_DWELL: rd_mux = 32'(cfg_q.mist_dwell);
         shear_seq_pkg::ADDR_TEST_LEN: rd_mux = 32'(cfg_q.test_len);
         shear_seq_pkg::ADDR_SCRAP_DIST: rd_mux = 32'(cfg_q.scrap_dist);
         shear_seq_pkg::ADDR_SHEAR_DWELL: rd_mux = 32'(cfg_q.shear_dwell);
         shear_seq_pkg::ADDR_STATUS: rd_mux = status_w;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q.cflow <= 1'b0;
         cfg_q.dump_delay <= shear_seq_pkg::TIME_RST;
         cfg_q.dump_dwell <= shear_seq_pkg::TIME_RST;
         cfg_q.mist_count <= shear_seq_pkg::MIST_COUNT_RST;
         cfg_q.mist_delay <= shear_seq_pkg::TIME_RST;
         cfg_q.mist_dwell <= shear_seq_pkg::TIME_RST;
         cfg_q.test_len <= shear_seq_pkg::TIME_RST;
         cfg_q.scrap_dist <= shear_seq_pkg::TIME_RST;
         cfg_q.shear_dwell <= shear_seq_pkg::SHEAR_DWELL_RST;
      end else if (wr_en) begin
         unique case (paddr)
            shear_seq_pkg::ADDR_CTRL: cfg_q.cflow <= pwdata[shear_seq_pkg::CTRL_CFLOW_BIT];
            shear_seq_pkg::ADDR_DUMP_DELAY: cfg_q.dump_delay <= pwdata[15:0];
            shear_seq_pkg::ADDR_DUMP_DWELL: cfg_q.dump_dwell <= pwdata[15:0];
            shear_seq_pkg::ADDR_MIST_COUNT: cfg_q.mist_count <= pwdata[15:0];
            shear_seq_pkg::ADDR_MIST_DELAY: cfg_q.mist_delay <= pwdata[15:0];
            shear_seq_pkg::ADDR_MIST_DWELL: cfg_q.mist_dwell <= pwdata[15:0];
            shear_seq_pkg::ADDR_TEST_LEN: cfg_q.test_len <= pwdata[15:0];
            shear_seq_pkg::ADDR_SCRAP_DIST: cfg_q.scrap_dist <= pwdata[15:0];
            shear_seq_pkg::ADDR_SHEAR_DWELL: cfg_q.shear_dwell <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // test request bit is write-one, self clearing, reads as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_req_q <= 1'b0;
      end else begin
         test_req_q <= wr_en && (paddr == shear_seq_pkg::ADDR_CTRL) && pwdata[shear_seq_pkg::CTRL_TEST_BIT];
      end
   end

   // ----------------------------------------------------------------
   // millisecond tick divider
   // ----------------------------------------------------------------
   logic [31:0] div_q;
   wire logic tick = (div_q == 32'(TICK_DIV - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 32'h0000_0000;
      end else begin
         div_q <= tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // shear cycle
   // ----------------------------------------------------------------
   shear_seq_pkg::sh_state_t sh_q;
   logic [15:0] sh_cnt_q;
   logic shear_done_q;
   logic auto_crop_q;
   logic home_ref_q;

   wire logic crop_now = run_rise & cfg_q.cflow;
   // in continuous flow, manual homes in idle, ignored in run; otherwise manual cuts
   wire logic man_cut = man_rise & ~cfg_q.cflow;
   wire logic man_home = man_rise & cfg_q.cflow & ~run_lvl;
   wire logic sh_start = shear_cmd | man_cut | crop_now;
   // a zero dwell waits for the complete switch alone
   wire logic sh_timeout = (sh_cnt_q == 16'h0000) && (cfg_q.shear_dwell != 16'h0000);
   wire logic sh_end = (sh_q == shear_seq_pkg::SH_DWELL) && (complete_lvl || sh_timeout);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= shear_seq_pkg::SH_IDLE;
         sh_cnt_q <= 16'h0000;
      end else begin
         unique case (sh_q)
            shear_seq_pkg::SH_IDLE: if (sh_start) begin
               sh_q <= shear_seq_pkg::SH_DWELL;
               sh_cnt_q <= cfg_q.shear_dwell;
            end
            shear_seq_pkg::SH_DWELL: if (sh_end) begin
               sh_q <= shear_seq_pkg::SH_IDLE;
            end else if (tick && sh_cnt_q != 16'h0000) begin
               sh_cnt_q <= sh_cnt_q - 16'h0001;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shear_done_q <= 1'b0;
         auto_crop_q <= 1'b0;
         home_ref_q <= 1'b0;
      end else begin
         shear_done_q <= sh_end;
         auto_crop_q <= crop_now;
         home_ref_q <= man_home;
      end
   end

   assign shear_out = (sh_q == shear_seq_pkg::SH_DWELL);
   assign auto_crop = auto_crop_q;
   assign home_ref = home_ref_q;

   // ----------------------------------------------------------------
   // mist counter
   // ----------------------------------------------------------------
   wire logic [16:0] cnt_inc = {1'b0, mist_cnt_q} + 17'h0_0001;
   wire logic mist_en = (cfg_q.mist_count != 16'h0000);
   wire logic mist_due = shear_done_q & mist_en & (cnt_inc >= {1'b0, cfg_q.mist_count});

   // counter preloaded so first cycle mists
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mist_cnt_q <= shear_seq_pkg::MIST_CNT_PRELOAD;
      end else if (shear_done_q && mist_en) begin
         mist_cnt_q <= mist_due ? 16'h0000 : cnt_inc[15:0];
      end
   end

   // ----------------------------------------------------------------
   // delay then dwell channels: dump table and mister
   // ----------------------------------------------------------------
   shear_seq_pkg::ch_state_t ch_q [shear_seq_pkg::NUM_CH];
   logic [15:0] ch_cnt_q [shear_seq_pkg::NUM_CH];
   logic [shear_seq_pkg::NUM_CH-1:0] ch_start;
   logic [15:0] ch_delay [shear_seq_pkg::NUM_CH];
   logic [15:0] ch_dwell [shear_seq_pkg::NUM_CH];

   assign ch_start[shear_seq_pkg::CH_DUMP] = shear_done_q;
   assign ch_start[shear_seq_pkg::CH_MIST] = mist_due;
   assign ch_delay[shear_seq_pkg::CH_DUMP] = cfg_q.dump_delay;
   assign ch_dwell[shear_seq_pkg::CH_DUMP] = cfg_q.dump_dwell;
   assign ch_delay[shear_seq_pkg::CH_MIST] = cfg_q.mist_delay;
   assign ch_dwell[shear_seq_pkg::CH_MIST] = cfg_q.mist_dwell;

   // a start while a channel is busy is dropped; the running cycle finishes
   for (genvar g = 0; g < shear_seq_pkg::NUM_CH; g++) begin : gen_ch
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ch_q[g] <= shear_seq_pkg::CH_IDLE;
            ch_cnt_q[g] <= 16'h0000;
         end else begin
            unique case (ch_q[g])
               shear_seq_pkg::CH_IDLE: if (ch_start[g]) begin
                  ch_q[g] <= shear_seq_pkg::CH_DELAY;
                  ch_cnt_q[g] <= ch_delay[g];
               end
               shear_seq_pkg::CH_DELAY: if (ch_cnt_q[g] == 16'h0000) begin
                  ch_q[g] <= shear_seq_pkg::CH_DWELL;
                  ch_cnt_q[g] <= ch_dwell[g];
               end else if (tick) begin
                  ch_cnt_q[g] <= ch_cnt_q[g] - 16'h0001;
               end
               shear_seq_pkg::CH_DWELL: if (ch_cnt_q[g] == 16'h0000) begin
                  ch_q[g] <= shear_seq_pkg::CH_IDLE;
               end else if (tick) begin
                  ch_cnt_q[g] <= ch_cnt_q[g] - 16'h0001;
               end
            endcase
         end
      end
   end

   assign dump_trigger = (ch_q[shear_seq_pkg::CH_DUMP] == shear_seq_pkg::CH_DWELL);
   assign mist_out = (ch_q[shear_seq_pkg::CH_MIST] == shear_seq_pkg::CH_DWELL);

   // ----------------------------------------------------------------
   // scrap marking and dump selector
   // ----------------------------------------------------------------
   logic scrap_mark_q;
   logic scrap_sel_q;
   logic test_part_q;

   // test request stands in for the sensor
   wire logic scrap_seen = sensor_lvl | test_req_q;
   wire logic mark_now = scrap_seen & ~scrap_lock_q;

   // sensor is ignored until the marked part leaves or the line halts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scrap_lock_q <= 1'b0;
         scrap_mark_q <= 1'b0;
         test_part_q <= 1'b0;
      end else begin
         scrap_mark_q <= mark_now;
         test_part_q <= test_req_q;
         if (mark_now) begin
            scrap_lock_q <= 1'b1;
         end else if (part_end || run_fall) begin
            scrap_lock_q <= 1'b0;
         end
      end
   end

   // selector follows current part, frozen while dumping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scrap_sel_q <= 1'b0;
      end else if (!dump_trigger) begin
         scrap_sel_q <= cur_part_scrap;
      end
   end

   assign scrap_mark = scrap_mark_q;
   assign scrap_dump_sel = scrap_sel_q;
   assign test_part = test_part_q;
   assign test_part_len = cfg_q.test_len;
   assign scrap_detect_en = (cfg_q.scrap_dist != 16'h0000);

endmodule

`default_nettype wire

// *** shear_seq_pkg.sv ***
// shared constants and types for the tube mill shear sequencer
// assumes a 32-bit apb register bus and a 50 MHz pclk
package shear_seq_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DUMP_DELAY = 8'h04;
   localparam logic [7:0] ADDR_DUMP_DWELL = 8'h08;
   localparam logic [7:0] ADDR_MIST_COUNT = 8'h0c;
   localparam logic [7:0] ADDR_MIST_DELAY = 8'h10;
   localparam logic [7:0] ADDR_MIST_DWELL = 8'h14;
   localparam logic [7:0] ADDR_TEST_LEN = 8'h18;
   localparam logic [7:0] ADDR_SCRAP_DIST = 8'h1c;
   localparam logic [7:0] ADDR_SHEAR_DWELL = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_CFLOW_BIT = 0;
   localparam int CTRL_TEST_BIT = 1;
   localparam int ST_SHEAR_BIT = 0;
   localparam int ST_DUMP_BIT = 1;
   localparam int ST_MIST_BIT = 2;
   localparam int ST_SCRAP_SEL_BIT = 3;
   localparam int ST_SCRAP_LOCK_BIT = 4;
   localparam int ST_RUN_BIT = 5;
   localparam int ST_CNT_LSB = 16;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [15:0] TIME_RST = 16'h0000;
   localparam logic [15:0] MIST_COUNT_RST = 16'h0001;
   localparam logic [15:0] SHEAR_DWELL_RST = 16'h0064;
   // preload: counter starts saturated so the first shear mists
   localparam logic [15:0] MIST_CNT_PRELOAD = 16'hffff;
   localparam int TICK_US = 1000;
   localparam int CLK_MHZ = 50;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int NUM_CH = 2;
   localparam int CH_DUMP = 0;
   localparam int CH_MIST = 1;

   typedef enum logic [2:0] {
      CH_IDLE = 3'b001,
      CH_DELAY = 3'b010,
      CH_DWELL = 3'b100
   } ch_state_t;

   typedef enum logic [1:0] {
      SH_IDLE = 2'b01,
      SH_DWELL = 2'b10
   } sh_state_t;

   // software settings, times in 1 ms ticks
   typedef struct packed {
      logic cflow;
      logic [15:0] dump_delay;
      logic [15:0] dump_dwell;
      logic [15:0] mist_count;
      logic [15:0] mist_delay;
      logic [15:0] mist_dwell;
      logic [15:0] test_len;
      logic [15:0] scrap_dist;
      logic [15:0] shear_dwell;
   } cfg_t;

endpackage

// *** shear_seq_pkg_note_unused.sv ***
`timescale 1ns/1ps

// *** shear_seq_checker.sv ***
// assertion checker for the shear sequencer, kept beside the design by bind
// assumes it sees every apb write that the design takes, on pclk
`timescale 1ns/1ps
`default_nettype none
module shear_seq_checker #(
   parameter int TICK_DIV = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic run_mode_pin,
   input wire logic cur_part_scrap,
   input wire logic shear_out,
   input wire logic dump_trigger,
   input wire logic scrap_dump_sel,
   input wire logic mist_out,
   input wire logic auto_crop,
   input wire logic test_part,
   input wire logic [15:0] test_part_len
);
   // ---------
   // settings shadow and interval counters
   // ---------
   wire wr = psel && penable && pwrite && pready;
   logic cflow_q;
   logic [15:0] tl_q;
   int dd_q, dw_q, mc_q, md_q, mw_q, sf_q, dl_q, ml_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cflow_q <= 1'b0;
         tl_q <= shear_seq_pkg::TIME_RST;
         {dd_q, dw_q, md_q, mw_q, sf_q, dl_q, ml_q} <= '0;
         mc_q <= int'(shear_seq_pkg::MIST_COUNT_RST);
      end else begin
         sf_q <= shear_out ? 0 : sf_q + 1;
         dl_q <= dump_trigger ? dl_q + 1 : 0;
         ml_q <= mist_out ? ml_q + 1 : 0;
         if (wr) begin
            case (paddr)
               shear_seq_pkg::ADDR_CTRL: cflow_q <= pwdata[0];
               shear_seq_pkg::ADDR_DUMP_DELAY: dd_q <= pwdata[15:0];
               shear_seq_pkg::ADDR_DUMP_DWELL: dw_q <= pwdata[15:0];
               shear_seq_pkg::ADDR_MIST_COUNT: mc_q <= pwdata[15:0];
               shear_seq_pkg::ADDR_MIST_DELAY: md_q <= pwdata[15:0];
               shear_seq_pkg::ADDR_MIST_DWELL: mw_q <= pwdata[15:0];
               shear_seq_pkg::ADDR_TEST_LEN: tl_q <= pwdata[15:0];
               default: ;
            endcase
         end
      end
   end
   // ---------
   // properties; tick phase allows one tick of slack
   // ---------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   function automatic bit inw(int v, int n, int s);
      return v >= (n - 1) * TICK_DIV && v <= (n + 1) * TICK_DIV + s;
   endfunction
   sequence s_test_wr;
      wr && paddr == shear_seq_pkg::ADDR_CTRL && pwdata[1];
   endsequence
   sequence s_run_on;
      cflow_q && $rose(run_mode_pin);
   endsequence
   property p_dump_delay;
      $rose(dump_trigger) |-> inw(sf_q, dd_q, 8);
   endproperty
   property p_dump_len;
      $fell(dump_trigger) |-> inw(dl_q, dw_q, 2);
   endproperty
   property p_mist_delay;
      $rose(mist_out) |-> inw(sf_q, md_q, 8);
   endproperty
   property p_mist_len;
      $fell(mist_out) |-> inw(ml_q, mw_q, 2);
   endproperty
   property p_mist_off;
      mc_q == 0 |-> !$rose(mist_out);
   endproperty
   property p_test;
      s_test_wr |-> ##[1:3] (test_part && test_part_len == tl_q);
   endproperty
   property p_crop;
      s_run_on |-> ##[1:8] auto_crop;
   endproperty
   property p_no_crop;
      !cflow_q |-> !auto_crop;
   endproperty
   property p_sel;
      !dump_trigger && !$past(dump_trigger) |-> scrap_dump_sel == $past(cur_part_scrap);
   endproperty
   property p_freeze;
      dump_trigger && $past(dump_trigger) |-> $stable(scrap_dump_sel);
   endproperty
   a_dump_delay: assert property (p_dump_delay) else $error("dump start off its delay");
   a_dump_len: assert property (p_dump_len) else $error("dump held wrong time");
   a_mist_delay: assert property (p_mist_delay) else $error("mist start off its delay");
   a_mist_len: assert property (p_mist_len) else $error("mist held wrong time");
   a_mist_off: assert property (p_mist_off) else $error("mist with zero count");
   a_test: assert property (p_test) else $error("test request gave no test part");
   a_crop: assert property (p_crop) else $error("no crop on run entry");
   a_no_crop: assert property (p_no_crop) else $error("crop without flow mode");
   a_sel: assert property (p_sel) else $error("scrap select not following part");
   a_freeze: assert property (p_freeze) else $error("scrap select moved during dump");
endmodule

bind tube_mill_shear_sequencer shear_seq_checker #(.TICK_DIV(TICK_DIV)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .run_mode_pin(run_mode_pin),
   .cur_part_scrap(cur_part_scrap), .shear_out(shear_out), .dump_trigger(dump_trigger),
   .scrap_dump_sel(scrap_dump_sel), .mist_out(mist_out), .auto_crop(auto_crop),
   .test_part(test_part), .test_part_len(test_part_len)
);
`default_nettype wire

// *** shear_press_model.sv ***
// shear press model: closes the complete switch a few cycles into a stroke
// assumes shear_out is a level that stays up until the stroke ends
`timescale 1ns/1ps
`default_nettype none
module shear_press_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic shear_out,
   input wire logic slow,
   output logic shear_complete_pin
);
   int cnt_q;
   // a slow press never closes the switch, so only the dwell timer can end it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 0;
         shear_complete_pin <= 1'b0;
      end else begin
         cnt_q <= shear_out ? cnt_q + 1 : 0;
         shear_complete_pin <= shear_out && !slow && cnt_q >= 4;
      end
   end
endmodule
`default_nettype wire

// *** tube_mill_shear_sequencer_bench.sv ***
// self-checking bench: apb master, pin stimulus, press model, mist model
// assumes the tick divider is shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tube_mill_shear_sequencer_bench;
   localparam int TD = 10;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic run_mode_pin, manual_shear_pin, shear_complete_pin, scrap_sensor_pin, shear_cmd, part_end;
   logic cur_part_scrap, shear_out, dump_trigger, scrap_dump_sel, mist_out, auto_crop, home_ref;
   logic scrap_mark, test_part, scrap_detect_en, s_sh, s_ac, s_hr, s_sm, s_tp;
   logic [15:0] test_part_len;
   logic mist_q[$];
   int bad_count, check_count, seed, dd, dw, md, mw, tl, mc, mcnt, k;
   logic [31:0] wv[6];
   logic [7:0] ra[6] = '{shear_seq_pkg::ADDR_MIST_COUNT, shear_seq_pkg::ADDR_SHEAR_DWELL,
      shear_seq_pkg::ADDR_DUMP_DELAY, shear_seq_pkg::ADDR_TEST_LEN, shear_seq_pkg::ADDR_STATUS, 8'h40};
   logic [31:0] rv[6] = '{32'h1, 32'h64, 32'h0, 32'h0, 32'hffff0000, 32'h0};
   logic [7:0] wa[6] = '{shear_seq_pkg::ADDR_DUMP_DELAY, shear_seq_pkg::ADDR_DUMP_DWELL,
      shear_seq_pkg::ADDR_MIST_COUNT, shear_seq_pkg::ADDR_MIST_DELAY, shear_seq_pkg::ADDR_MIST_DWELL,
      shear_seq_pkg::ADDR_SHEAR_DWELL};
   tube_mill_shear_sequencer #(.TICK_DIV(TD)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .run_mode_pin(run_mode_pin), .manual_shear_pin(manual_shear_pin),
      .shear_complete_pin(shear_complete_pin), .scrap_sensor_pin(scrap_sensor_pin), .shear_cmd(shear_cmd),
      .part_end(part_end), .cur_part_scrap(cur_part_scrap), .shear_out(shear_out),
      .dump_trigger(dump_trigger), .scrap_dump_sel(scrap_dump_sel), .mist_out(mist_out),
      .auto_crop(auto_crop), .home_ref(home_ref), .scrap_mark(scrap_mark), .test_part(test_part),
      .test_part_len(test_part_len), .scrap_detect_en(scrap_detect_en));
   shear_press_model i_press (.pclk(pclk), .presetn(presetn), .shear_out(shear_out), .slow(slow),
      .shear_complete_pin(shear_complete_pin));
   // ---------
   // bus cycles, models and watchers
   // ---------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic err);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   function automatic logic mist_due();
      if (mc == 0) return 1'b0;
      if (mcnt + 1 >= mc) begin
         mcnt = 0;
         return 1'b1;
      end
      mcnt++;
      return 1'b0;
   endfunction
   function automatic logic win(int v, int n);
      return v >= (n - 1) * TD && v <= (n + 1) * TD + 8;
   endfunction
   task automatic watch(input int n);
      {s_sh, s_ac, s_hr, s_sm, s_tp} = '0;
      repeat (n) begin
         @(posedge pclk);
         {s_sh, s_ac, s_hr, s_sm, s_tp} |= {shear_out, auto_crop, home_ref, scrap_mark, test_part};
      end
   endtask
   task automatic shear(input logic mx);
      int sl = -1, dr = -1, dn = 0, mr = -1, mn = 0;
      @(posedge pclk);
      shear_cmd <= 1'b1;
      for (int t = 0; t < 300; t++) begin
         @(posedge pclk);
         shear_cmd <= 1'b0;
         cur_part_scrap <= 1'($random(seed));
         if (shear_out === 1'b1) sl = t;
         if (dump_trigger === 1'b1 && dr < 0) dr = t;
         if (mist_out === 1'b1 && mr < 0) mr = t;
         dn += int'(dump_trigger === 1'b1);
         mn += int'(mist_out === 1'b1);
      end
      `CHK("dump_delay", 1'b1, win(dr - sl, dd))
      `CHK("dump_dwell", 1'b1, win(dn, dw))
      `CHK("mist_fired", mx, mr >= 0)
      if (mx) begin
         `CHK("mist_delay", 1'b1, win(mr - sl, md))
         `CHK("mist_dwell", 1'b1, win(mn, mw))
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ---------
   // clock, watchdog and main sequence
   // ---------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      close_out();
   end
   initial begin
      seed = 32'h6eeb7642;
      {psel, penable, pwrite, paddr, pwdata, slow} = '0;
      {run_mode_pin, manual_shear_pin, scrap_sensor_pin, shear_cmd, part_end, cur_part_scrap} = '0;
      {bad_count, check_count, mcnt, mc} = {32'd0, 32'd0, 32'd65535, 32'd2};
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 0; k < 6; k++) begin
         apb(1'b0, ra[k], 32'h0, r, e);
         `CHK("reset_read", rv[k], r)
         `CHK("slverr", k == 5, e)
      end
      dd = 2 + $unsigned($random(seed)) % 3;
      dw = 2 + $unsigned($random(seed)) % 3;
      md = 2 + $unsigned($random(seed)) % 3;
      mw = 2 + $unsigned($random(seed)) % 3;
      wv = '{dd, dw, mc, md, mw, 5};
      for (k = 0; k < 6; k++) begin
         apb(1'b1, wa[k], wv[k], r, e);
         apb(1'b0, wa[k], 32'h0, r, e);
         `CHK("readback", wv[k], r)
      end
      for (k = 0; k < 4; k++) mist_q.push_back(mist_due());
      for (k = 0; k < 4; k++) begin
         slow <= k[0];
         shear(mist_q.pop_front());
      end
      apb(1'b1, shear_seq_pkg::ADDR_MIST_COUNT, 32'h0, r, e);
      mc = 0;
      shear(mist_due());
      tl = 1 + $unsigned($random(seed)) % 32'hfffe;
      apb(1'b1, shear_seq_pkg::ADDR_TEST_LEN, tl, r, e);
      apb(1'b1, shear_seq_pkg::ADDR_CTRL, 32'h2, r, e);
      watch(10);
      `CHK("test_part", 1'b1, s_tp)
      `CHK("test_mark", 1'b1, s_sm)
      `CHK("test_len", tl[15:0], test_part_len)
      part_end <= 1'b1;
      watch(1);
      {part_end, scrap_sensor_pin, cur_part_scrap} <= 3'b011;
      watch(10);
      `CHK("sensor_mark", 1'b1, s_sm)
      `CHK("scrap_sel", 1'b1, scrap_dump_sel)
      {part_end, scrap_sensor_pin} <= 2'b10;
      apb(1'b1, shear_seq_pkg::ADDR_SCRAP_DIST, 32'h0, r, e);
      part_end <= 1'b0;
      watch(1);
      `CHK("detect_off", 1'b0, scrap_detect_en)
      apb(1'b1, shear_seq_pkg::ADDR_SCRAP_DIST, tl, r, e);
      watch(1);
      `CHK("detect_on", 1'b1, scrap_detect_en)
      apb(1'b1, shear_seq_pkg::ADDR_CTRL, 32'h1, r, e);
      run_mode_pin <= 1'b1;
      watch(20);
      `CHK("crop_on_run", 1'b1, s_ac)
      `CHK("crop_cut", 1'b1, s_sh)
      watch(200);
      manual_shear_pin <= 1'b1;
      watch(20);
      `CHK("manual_in_run", 1'b0, s_sh)
      {manual_shear_pin, run_mode_pin} <= 2'b00;
      watch(6);
      manual_shear_pin <= 1'b1;
      watch(20);
      `CHK("manual_home", 1'b1, s_hr)
      `CHK("manual_no_cut", 1'b0, s_sh)
      manual_shear_pin <= 1'b0;
      apb(1'b1, shear_seq_pkg::ADDR_CTRL, 32'h0, r, e);
      run_mode_pin <= 1'b1;
      watch(20);
      `CHK("no_crop", 1'b0, s_ac)
      run_mode_pin <= 1'b0;
      watch(6);
      manual_shear_pin <= 1'b1;
      watch(20);
      `CHK("manual_cut", 1'b1, s_sh)
      manual_shear_pin <= 1'b0;
      watch(200);
      close_out();
   end
endmodule
`default_nettype wire
